// File: ccp_pkg.sv
// Behaviour
// - read strobe low in t2, t3, wait states
// - read strobe high until bus floated on hold
// - ready raised by device, presented pre-synchronised
// - maskable request sampled in final instruction cycle
// - maskable request ignored while enable flag clear
// - non-maskable rising edge gives type 2 interrupt
// - non-maskable edge synchronised, serviced after instruction
// - wait-for-test idles until test input low
// - reset stops activity, restarts, synchronised internally
// - system holds reset high four cycles minimum
// - clock source supplies 33% duty clock; here the testbench clk_sys runs at 50% duty, with no duty shaping
// - mode strap selects minimum or maximum mode
// - memory/io line valid from prior t4 to final t4; here it switches only on entering t1
package ccp_pkg;
    localparam int          RESET_MIN_CYC   = 4;
    localparam int          CLK_DUTY_PCT    = 33;
    localparam logic [7:0]  NMI_TYPE        = 8'h02;
    localparam logic [1:0]  KIND_MEM_RD     = 2'h0;
    localparam logic [1:0]  KIND_IO_RD      = 2'h1;
    localparam logic [1:0]  KIND_INTA       = 2'h2;
    localparam logic [1:0]  KIND_WAIT_TEST  = 2'h3;
    localparam logic [3:0]  INSTR_CYCLES    = 4'h4;
    localparam logic [19:0] RESET_ADDR      = 20'hFFFF0;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_T1,
        ST_T2,
        ST_T3,
        ST_TW,
        ST_T4
    } ccp_bus_t;

    function automatic logic ccp_is_mem(input logic [1:0] kind);
        return kind == KIND_MEM_RD;
    endfunction
endpackage

// File: ccp_if.sv
`timescale 1ns/1ps
interface ccp_if;
    logic rd_n_o;      // read strobe out
    logic rd_n_oe_n;   // low while driven
    logic mem_io_o;
    logic mem_io_oe_n;
    logic ready;
    logic maskable_irq;
    logic nmi;
    logic test_n;
    logic reset;
    logic mode_strap;
    logic hold;
    logic hlda;

    modport cpu (
        output rd_n_o, rd_n_oe_n, mem_io_o, mem_io_oe_n, hlda,
        input  ready, maskable_irq, nmi, test_n, reset, mode_strap, hold
    );
    modport sys (
        input  rd_n_o, rd_n_oe_n, mem_io_o, mem_io_oe_n, hlda,
        output ready, maskable_irq, nmi, test_n, reset, mode_strap, hold
    );
endinterface

// File: ccp_cpu_end.sv
`timescale 1ns/1ps
module ccp_cpu_end
    import ccp_pkg::*;
(
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    // pins
    ccp_if.cpu              pins,
    // user side
    input  wire logic       req_valid,
    input  wire logic [1:0] req_kind,
    input  wire logic       irq_enable,
    output logic            req_ready,
    output logic            done_pulse,
    output logic            irq_take,
    output logic [7:0]      irq_type,
    output logic            in_reset,
    output logic            min_mode,
    output logic            test_waiting
);
    // reset, nmi and test come from pins: two flops first
    localparam int         SYNC_N   = 3;
    localparam logic [2:0] SYNC_RST = 3'h4;  // test idles high, reset and nmi low

    logic [SYNC_N-1:0] pin_raw;
    logic [SYNC_N-1:0] pin_sync;
    logic              reset_now;
    logic              nmi_sync;
    logic              test_sync_n;
    logic              nmi_edge;
    logic              instr_end;
    logic              mode_q, mode_d, mode_ok_q, mode_ok_d;
    logic              nmi_prev_q, nmi_prev_d, nmi_pend_q, nmi_pend_d;
    logic              take_q, take_d;
    logic [7:0]        type_q, type_d;
    ccp_bus_t          st_q, st_d;
    logic [1:0]        kind_q, kind_d;
    logic [3:0]        icnt_q, icnt_d;
    logic              mio_q, mio_d, hlda_q, hlda_d, done_q, done_d;

    // only memory and io reads pulse the read strobe
    function automatic logic is_read(input logic [1:0] kind);
        return (kind == KIND_MEM_RD) || (kind == KIND_IO_RD);
    endfunction

    function automatic logic is_test(input logic [1:0] kind);
        return kind == KIND_WAIT_TEST;
    endfunction

    assign pin_raw = {pins.test_n, pins.nmi, pins.reset};

    // identical two-flop synchronisers; nothing reads stage one
    for (genvar g = 0; g < SYNC_N; g++) begin : g_sync
        logic s1_q, s1_d, s2_q, s2_d;

        always_comb begin
            s1_d = pin_raw[g];
            s2_d = s1_q;
        end

        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                s1_q <= SYNC_RST[g];
                s2_q <= SYNC_RST[g];
            end else begin
                s1_q <= s1_d;
                s2_q <= s2_d;
            end
        end

        assign pin_sync[g] = s2_q;
    end

    assign reset_now   = pin_sync[0];
    assign nmi_sync    = pin_sync[1];
    assign test_sync_n = pin_sync[2];
    assign nmi_edge    = nmi_sync && !nmi_prev_q;
    assign instr_end   = !reset_now && (st_q == ST_T4) && (icnt_q == INSTR_CYCLES - 4'h1);

    // strap read once after rst_n; later strap moves are ignored
    always_comb begin
        mode_ok_d = 1'b1;
        mode_d    = mode_ok_q ? mode_q : pins.mode_strap;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mode_q    <= 1'b1;
            mode_ok_q <= 1'b0;
        end else begin
            mode_q    <= mode_d;
            mode_ok_q <= mode_ok_d;
        end
    end

    // an edge landing on the instruction end is taken at once, not lost
    always_comb begin
        nmi_prev_d = nmi_sync;
        nmi_pend_d = nmi_pend_q;
        take_d     = 1'b0;
        type_d     = type_q;
        if (nmi_edge)
            nmi_pend_d = 1'b1;
        if (reset_now) begin
            nmi_pend_d = 1'b0;
        end else if (instr_end) begin
            if (nmi_pend_q || nmi_edge) begin
                take_d     = 1'b1;
                type_d     = NMI_TYPE;
                nmi_pend_d = 1'b0;
            end else if (pins.maskable_irq && irq_enable) begin
                take_d = 1'b1;
                type_d = 8'h00;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            nmi_prev_q <= 1'b0;
            nmi_pend_q <= 1'b0;
            take_q     <= 1'b0;
            type_q     <= 8'h00;
        end else begin
            nmi_prev_q <= nmi_prev_d;
            nmi_pend_q <= nmi_pend_d;
            take_q     <= take_d;
            type_q     <= type_d;
        end
    end

    always_comb begin
        st_d   = st_q;
        kind_d = kind_q;
        icnt_d = icnt_q;
        mio_d  = mio_q;
        hlda_d = hlda_q;
        done_d = 1'b0;
        if (reset_now) begin
            st_d   = ST_IDLE;
            icnt_d = 4'h0;
            hlda_d = 1'b0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    // hold granted only between cycles, never inside one
                    hlda_d = pins.hold;
                    if (!pins.hold && req_valid) begin
                        kind_d = req_kind;
                        mio_d  = ccp_is_mem(req_kind);
                        st_d   = ST_T1;
                    end
                end
                ST_T1: st_d = is_test(kind_q) ? ST_TW : ST_T2;
                ST_T2: st_d = ST_T3;
                ST_T3: st_d = pins.ready ? ST_T4 : ST_TW;
                ST_TW: begin
                    if (is_test(kind_q)) begin
                        if (!test_sync_n)
                            st_d = ST_T4;
                    end else if (pins.ready) begin
                        st_d = ST_T4;
                    end
                end
                ST_T4: begin
                    // every fourth finished cycle closes an instruction
                    done_d = 1'b1;
                    st_d   = ST_IDLE;
                    icnt_d = instr_end ? 4'h0 : icnt_q + 4'h1;
                end
                default: st_d = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q   <= ST_IDLE;
            kind_q <= 2'h0;
            icnt_q <= 4'h0;
            mio_q  <= 1'b1;
            hlda_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            st_q   <= st_d;
            kind_q <= kind_d;
            icnt_q <= icnt_d;
            mio_q  <= mio_d;
            hlda_q <= hlda_d;
            done_q <= done_d;
        end
    end

    // strobe low in t2/t3/wait of reads, not of inta or test wait
    assign pins.rd_n_o      = !((st_q == ST_T2 || st_q == ST_T3 || st_q == ST_TW)
                                && is_read(kind_q));
    assign pins.rd_n_oe_n   = hlda_q;
    assign pins.mem_io_o    = mio_q;
    assign pins.mem_io_oe_n = hlda_q;
    assign pins.hlda        = hlda_q;

    // refused while the synchronised reset or a hold request is up
    assign req_ready    = (st_q == ST_IDLE) && !reset_now && !pins.hold;
    assign done_pulse   = done_q;
    assign irq_take     = take_q;
    assign irq_type     = type_q;
    assign in_reset     = reset_now;
    assign min_mode     = mode_q;
    assign test_waiting = (st_q == ST_TW) && is_test(kind_q);
endmodule // ccp_cpu_end

// File: ccp_sys_end.sv
`timescale 1ns/1ps
module ccp_sys_end
    import ccp_pkg::*;
(
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // pins
    ccp_if.sys        pins,
    // user side
    input  wire logic reset_req,
    input  wire logic dev_ready,
    input  wire logic irq_level,
    input  wire logic nmi_level,
    input  wire logic test_level_n,
    input  wire logic hold_req,
    input  wire logic strap_min,
    output logic      reset_busy
);
    logic [2:0] rcnt_q, rcnt_d;
    logic       rdy_q, rdy_d;

    always_comb begin
        rcnt_d = rcnt_q;
        if (reset_req)
            rcnt_d = 3'(RESET_MIN_CYC);
        else if (rcnt_q != 3'h0)
            rcnt_d = rcnt_q - 3'h1;
        rdy_d = dev_ready;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rcnt_q <= 3'(RESET_MIN_CYC);
            rdy_q  <= 1'b0;
        end else begin
            rcnt_q <= rcnt_d;
            rdy_q  <= rdy_d;
        end
    end

    // clk_sys stands in for the 33% duty clock; no duty shaping here
    assign pins.reset        = rcnt_q != 3'h0;
    assign pins.ready        = rdy_q;
    assign pins.maskable_irq = irq_level;
    assign pins.nmi          = nmi_level;
    assign pins.test_n       = test_level_n;
    assign pins.hold         = hold_req;
    assign pins.mode_strap   = strap_min;
    assign reset_busy        = pins.reset;
endmodule // ccp_sys_end

// File: ccp_asserts.sv
`timescale 1ns/1ps
module ccp_asserts (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // pins
    input wire logic rd_n_o,
    input wire logic rd_n_oe_n,
    input wire logic mem_io_o,
    input wire logic mem_io_oe_n,
    input wire logic ready,
    input wire logic reset,
    input wire logic hold,
    input wire logic hlda
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    strobe_min_a: assert property ($fell(rd_n_o) && !reset |=> !rd_n_o)
        else $error("read strobe shorter than two cycles");
    wait_hold_a: assert property (!rd_n_o && !ready && !reset |=> !rd_n_o)
        else $error("read strobe released while not ready");
    strobe_end_a: assert property ($past(!rd_n_o) && !rd_n_o && ready && !reset |=> rd_n_o)
        else $error("read strobe held after ready");
    memio_hold_a: assert property (!rd_n_o |-> $stable(mem_io_o))
        else $error("memory io line moved during strobe");
    float_high_a: assert property (hlda |-> rd_n_oe_n && mem_io_oe_n && rd_n_o)
        else $error("pins driven during hold grant");
    grant_cause_a: assert property ($rose(hlda) |-> $past(hold) && rd_n_o)
        else $error("grant without hold request");
    drive_back_a: assert property (!hold && hlda |=> !hlda && !rd_n_oe_n)
        else $error("grant kept after hold dropped");
    reset_len_a: assert property ($rose(reset) |-> reset[*4])
        else $error("reset pin high under four cycles");
endmodule // ccp_asserts

// File: test_cpu_control_pin_logic.sv
`timescale 1ns/1ps
module test_cpu_control_pin_logic;
    import ccp_pkg::*;
`define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin fails++; \
    $display("mismatch %s expected %0h seen %0h", nm, e, a); end end
    logic       clk_sys, rst_n, req_valid, irq_enable, reset_req, dev_ready, irq_level;
    logic       nmi_level, test_level_n, hold_req, strap_min, req_ready, done_pulse, irq_take;
    logic       in_reset, min_mode, test_waiting, reset_busy, mio, tw;
    logic [1:0] req_kind;
    logic [7:0] irq_type, ttype;
    int         fails, total_checks, cyc, lat, low, ntake, n0, nt0;
    // kind, ready stall w, latency, strobe cycles, mem/io level (-1 unchecked)
    int         rows[4][5] = '{'{0, 0, 4, 2, 1}, '{1, 0, 4, 2, 0}, '{2, 0, 4, 0, -1},
                               '{0, 6, 8, 6, 1}};
    ccp_if pins_if ();
    ccp_cpu_end ccp_cpu_end_inst (.clk_sys(clk_sys), .rst_n(rst_n), .pins(pins_if),
        .req_valid(req_valid), .req_kind(req_kind), .irq_enable(irq_enable),
        .req_ready(req_ready), .done_pulse(done_pulse), .irq_take(irq_take),
        .irq_type(irq_type), .in_reset(in_reset), .min_mode(min_mode),
        .test_waiting(test_waiting));
    ccp_sys_end ccp_sys_end_inst (.clk_sys(clk_sys), .rst_n(rst_n), .pins(pins_if),
        .reset_req(reset_req), .dev_ready(dev_ready), .irq_level(irq_level),
        .nmi_level(nmi_level), .test_level_n(test_level_n), .hold_req(hold_req),
        .strap_min(strap_min), .reset_busy(reset_busy));
    ccp_asserts ccp_asserts_inst (.clk_sys(clk_sys), .rst_n(rst_n), .rd_n_o(pins_if.rd_n_o),
        .rd_n_oe_n(pins_if.rd_n_oe_n), .mem_io_o(pins_if.mem_io_o), .ready(pins_if.ready),
        .mem_io_oe_n(pins_if.mem_io_oe_n), .reset(pins_if.reset), .hold(pins_if.hold),
        .hlda(pins_if.hlda));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        ntake <= ntake + int'(irq_take === 1'b1);
        if (irq_take === 1'b1) ttype <= irq_type;
        if (cyc == 4000) begin
            fails++;
            stop_test();
        end
    end

    // one transfer; w stalls ready, or holds the test input high for kind 3
    task automatic run_cyc(input logic [1:0] k, input int w);
        lat = 0;
        low = 0;
        n0 = 0;
        @(negedge clk_sys);
        req_valid = 1'b1;
        req_kind = k;
        dev_ready = (k == 2'h3) || (w == 0);
        test_level_n = (k == 2'h3);
        while (req_ready !== 1'b1 && n0 < 50) begin
            n0++;
            @(negedge clk_sys);
        end
        @(negedge clk_sys);
        req_valid = 1'b0;
        while (done_pulse !== 1'b1 && lat < 60) begin
            lat++;
            low += int'(pins_if.rd_n_o === 1'b0);
            if (lat == 1) mio = pins_if.mem_io_o;
            if (lat == 2) tw = test_waiting;
            if (lat >= w) begin
                dev_ready = 1'b1;
                test_level_n = 1'b0;
            end
            @(negedge clk_sys);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        {rst_n, req_valid, irq_enable, reset_req, irq_level, nmi_level, hold_req} = 7'h00;
        {dev_ready, test_level_n, strap_min} = 3'h7;
        req_kind = 2'h0;
        repeat (2) @(negedge clk_sys);
        rst_n = 1'b1;
        @(negedge clk_sys);
        `CHK("min_mode", 1'b1, min_mode)
        foreach (rows[i]) begin
            run_cyc(2'(rows[i][0]), rows[i][1]);
            `CHK("latency", rows[i][2], lat)
            `CHK("strobe", rows[i][3], low)
            if (rows[i][4] >= 0) `CHK("mem_io", 1'(rows[i][4]), mio)
        end
        $display("table done");
        run_cyc(2'h3, 5);
        `CHK("test_wait", 1'b1, tw)
        `CHK("test_resume", 1'b1, lat > 5 && lat < 12)
        $display("test wait done");
        hold_req = 1'b1;
        repeat (3) @(negedge clk_sys);
        `CHK("hlda", 1'b1, pins_if.hlda)
        `CHK("refused", 1'b0, req_ready)
        hold_req = 1'b0;
        irq_level = 1'b1;
        for (int p = 0; p < 3; p++) begin
            irq_enable = (p == 2);
            nmi_level = (p == 1);
            nt0 = ntake;
            repeat (4) run_cyc(2'h0, 0);
            repeat (2) @(negedge clk_sys);
            `CHK("irq_taken", int'(p != 0), ntake - nt0)
            if (p != 0) `CHK("irq_type", (p == 1) ? NMI_TYPE : 8'h00, ttype)
        end
        irq_level = 1'b0;
        $display("hold and interrupts done");
        dev_ready = 1'b0;
        req_valid = 1'b1;
        repeat (6) @(negedge clk_sys);
        req_valid = 1'b0;
        `CHK("rd_wait", 1'b0, pins_if.rd_n_o)
        reset_req = 1'b1;
        @(negedge clk_sys);
        reset_req = 1'b0;
        dev_ready = 1'b1;
        n0 = 0;
        while (reset_busy === 1'b1 && n0 < 20) begin
            n0++;
            @(negedge clk_sys);
        end
        `CHK("reset_len", 4, n0)
        `CHK("in_reset", 1'b1, in_reset)
        `CHK("rd_stop", 1'b1, pins_if.rd_n_o)
        run_cyc(2'h0, 0);
        `CHK("restart", 4, lat)
        $display("reset done");
        // second rst_n with the strap moved: maximum mode must be captured
        strap_min = 1'b0;
        rst_n = 1'b0;
        @(negedge clk_sys);
        rst_n = 1'b1;
        @(negedge clk_sys);
        `CHK("max_mode", 1'b0, min_mode)
        `CHK("rd_idle", 1'b1, pins_if.rd_n_o)
        $display("strap done");
        stop_test();
    end
endmodule // test_cpu_control_pin_logic
